// >>> hmrc_pkg.sv
// Package with register map, field layout, reset values and timing counts.
`default_nettype none
package hmrc_pkg;

  // Byte addresses of the register bank.
  localparam logic [7:0] ADDR_HOUR_HIGH  = 8'hFB;
  localparam logic [7:0] ADDR_HOUR_LOW   = 8'hFC;
  localparam logic [7:0] ADDR_DATA_READY = 8'hFD;
  localparam logic [7:0] ADDR_USER_CTRL  = 8'hFE;
  localparam logic [7:0] ADDR_RESET_OUT  = 8'hFF;

  // Hour meter layout.
  localparam int HOUR_BITS      = 15;
  localparam int HOUR_FAULT_BIT = 7;

  // Data ready flags: bit 7 temperature down to bit 3 receive power.
  localparam int READY_COUNT = 5;
  localparam int READY_LSB   = 3;

  // User control field positions.
  localparam int UC_MASK_BIT  = 6;
  localparam int UC_FLAG_BIT  = 5;
  localparam int UC_IE_BIT    = 4;
  localparam int UC_PSEL_LSB  = 2;
  localparam int UC_MSEL_LSB  = 0;

  // Reset values.
  localparam logic [7:0] USER_CTRL_RESET = 8'h20;
  localparam logic [7:0] DATA_READY_RESET = 8'h00;
  localparam logic [2:0] RESET_FIELD_IDLE = 3'h0;
  localparam logic [2:0] RESET_FIELD_FIRE = 3'h7;
  localparam int RESET_FIELD_BITS = 3;

  // Timing in the units printed, and derived cycle counts at 50 MHz.
  localparam int CLK_MHZ        = 50;
  localparam int PULSE_TIME_US  = 125;
  localparam int CLEAR_TIME_US  = 22500;
  localparam int PULSE_CYCLES   = PULSE_TIME_US * CLK_MHZ;
  localparam int CLEAR_CYCLES   = CLEAR_TIME_US * CLK_MHZ;

  // Register access from the serial interface, one byte per access.
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } hmrc_bus_s;

  // Non-volatile part of the user control register.
  typedef struct packed {
    logic       irq_mask;
    logic       irq_enable;
    logic [1:0] power_sel;
    logic [1:0] mod_sel;
  } hmrc_ucfg_s;

  // Reset output sequencer states, Gray along idle, pulse, wait.
  typedef enum logic [1:0] {
    RS_IDLE  = 2'b00,
    RS_PULSE = 2'b01,
    RS_WAIT  = 2'b11
  } hmrc_rs_e;

endpackage
`default_nettype wire

// >>> hmrc_reset_seq.sv
// Sequencer that pulses the open-drain reset pin and times the field clear.
`timescale 1ns/1ps
`default_nettype none
module hmrc_reset_seq #(
  parameter int PULSE_CYC = hmrc_pkg::PULSE_CYCLES,
  parameter int CLEAR_CYC = hmrc_pkg::CLEAR_CYCLES
) (
  // Clock and reset.
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  // Control.
  input  wire logic i_start,
  output logic      o_drive,
  output logic      o_clear,
  output logic      o_busy
);
  localparam int CW = $clog2(CLEAR_CYC + PULSE_CYC + 1);
  localparam logic [CW-1:0] PULSE_LAST = CW'(PULSE_CYC - 1);
  localparam logic [CW-1:0] CLEAR_LAST = CW'(CLEAR_CYC - 1);

  hmrc_pkg::hmrc_rs_e state;
  hmrc_pkg::hmrc_rs_e next_state;
  logic [CW-1:0]      count;
  logic [CW-1:0]      next_count;
  logic               next_drive;
  logic               next_clear;

  always_comb begin
    next_state = state;
    next_count = count + CW'(1);
    next_clear = 1'b0;
    unique case (state)
      hmrc_pkg::RS_IDLE: begin
        next_count = '0;
        if (i_start) begin
          next_state = hmrc_pkg::RS_PULSE;
        end
      end
      hmrc_pkg::RS_PULSE: begin
        if (count == PULSE_LAST) begin
          next_state = hmrc_pkg::RS_WAIT;
          next_count = '0;
        end
      end
      hmrc_pkg::RS_WAIT: begin
        if (count == CLEAR_LAST) begin
          next_state = hmrc_pkg::RS_IDLE;
          next_count = '0;
          next_clear = 1'b1;
        end
      end
      default: begin
        next_state = hmrc_pkg::RS_IDLE;
        next_count = '0;
      end
    endcase
    next_drive = (next_state == hmrc_pkg::RS_PULSE);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state   <= hmrc_pkg::RS_IDLE;
      count   <= '0;
      o_drive <= 1'b0;
      o_clear <= 1'b0;
    end else begin
      state   <= next_state;
      count   <= next_count;
      o_drive <= next_drive;
      o_clear <= next_clear;
    end
  end

  assign o_busy = (state != hmrc_pkg::RS_IDLE);

  a_pulse_start: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_start && state == hmrc_pkg::RS_IDLE) |=> o_drive)
    else $error("reset pin not driven after start");
  a_pulse_length: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (state == hmrc_pkg::RS_PULSE && count == PULSE_LAST) |=> !o_drive)
    else $error("reset pin pulse too long");
endmodule
`default_nettype wire

// >>> hmrc_regs.sv
// Hour meter, data ready, user control and reset output register bank.
//
// Notes on behaviour
// - 15-bit hour count: upper seven bits in high register, low byte in low.
// - High register bit 7 reads 1 when the stored hour count is corrupt.
// - Hour count lives in non-volatile storage and survives power loss.
// - Ready flags bit 7 temperature to bit 3 receive power; 2:0 reserved.
// - A ready flag reads 1 when its result register holds a new result.
// - Control bits 3:2 pick the laser power setpoint; 11 is reserved.
// - Control bits 1:0 pick the modulation setpoint; 11 is reserved.
// - Host interrupt asserts only while global enable bit 4 is 1.
// - Writing enable 1 while interrupt is asserted clears a pending external event; a power-on flag with mask set keeps it asserted.
// - Every power-on reset sets the power-on flag, bit 5.
// - With mask bit 6 set, the power-on event also raises the interrupt.
// - Reading user control clears the power-on flag and its interrupt.
// - Setting the mask with flag already 1 asserts interrupt until read.
// - Mask, enable and both select fields are kept non-volatile.
// - Host writes 0 to control bit 7; its read value is undefined.
// - Reset output: bits 7:3 reserved read-only, 2:0 read/write, reset 0.
// - In reset mode writing 111 drives the pin low about 125 us.
// - After the pin releases, the field returns to 000 after 22.5 ms.
// - Outside reset mode the field has no effect on the pin.
`timescale 1ns/1ps
`default_nettype none
module hmrc_regs #(
  parameter int PULSE_CYC = hmrc_pkg::PULSE_CYCLES,
  parameter int CLEAR_CYC = hmrc_pkg::CLEAR_CYCLES
) (
  // Clock and reset.
  input  wire logic                            i_ref_clk,
  input  wire logic                            i_rst_n,
  // Register access.
  input  wire hmrc_pkg::hmrc_bus_s             i_bus,
  output logic [7:0]                           o_reg_rdata,
  output logic                                 o_reg_rvalid,
  // Non-volatile storage image.
  input  wire logic [hmrc_pkg::HOUR_BITS-1:0]  i_nv_hours,
  input  wire logic                            i_nv_fault,
  input  wire hmrc_pkg::hmrc_ucfg_s            i_nv_user,
  output logic [hmrc_pkg::HOUR_BITS-1:0]       o_nv_hours,
  output logic                                 o_nv_hours_wr,
  output hmrc_pkg::hmrc_ucfg_s                 o_nv_user,
  output logic                                 o_nv_user_wr,
  // Timebase and converter events.
  input  wire logic                            i_hour_tick,
  input  wire logic [hmrc_pkg::READY_COUNT-1:0] i_conv_done,
  input  wire logic [hmrc_pkg::READY_COUNT-1:0] i_result_read,
  // Interrupts.
  input  wire logic                            i_irq_event,
  output logic                                 o_int_n,
  // Setpoint selects.
  output logic [1:0]                           o_power_sel,
  output logic [1:0]                           o_mod_sel,
  // Reset output pin.
  input  wire logic                            i_reset_mode,
  output logic                                 o_pin_out,
  output logic                                 o_pin_oe
);
  localparam int RC = hmrc_pkg::READY_COUNT;
  localparam int HB = hmrc_pkg::HOUR_BITS;

  // Register state.
  logic                  loaded;
  logic                  next_loaded;
  logic [HB-1:0]         hours;
  logic [HB-1:0]         next_hours;
  logic                  fault;
  logic                  next_fault;
  logic                  hours_wr;
  logic                  next_hours_wr;
  logic [RC-1:0]         ready;
  logic [RC-1:0]         next_ready;
  hmrc_pkg::hmrc_ucfg_s  ucfg;
  hmrc_pkg::hmrc_ucfg_s  next_ucfg;
  logic                  ucfg_wr;
  logic                  next_ucfg_wr;
  logic                  por_flag;
  logic                  next_por_flag;
  logic                  ext_pend;
  logic                  next_ext_pend;
  logic                  int_n;
  logic                  next_int_n;
  logic [2:0]            rst_field;
  logic [2:0]            next_rst_field;
  logic [7:0]            rdata;
  logic [7:0]            next_rdata;
  logic                  rvalid;
  logic                  next_rvalid;
  logic                  rs_start;
  logic                  rs_drive;
  logic                  rs_clear;
  logic                  rs_busy;

  // Access decode.
  logic wr_high;
  logic wr_low;
  logic wr_uc;
  logic wr_rst;
  logic rd_uc;
  assign wr_high = i_bus.wr && (i_bus.addr == hmrc_pkg::ADDR_HOUR_HIGH);
  assign wr_low  = i_bus.wr && (i_bus.addr == hmrc_pkg::ADDR_HOUR_LOW);
  assign wr_uc   = i_bus.wr && (i_bus.addr == hmrc_pkg::ADDR_USER_CTRL);
  assign wr_rst  = i_bus.wr && (i_bus.addr == hmrc_pkg::ADDR_RESET_OUT);
  assign rd_uc   = i_bus.rd && (i_bus.addr == hmrc_pkg::ADDR_USER_CTRL);

  // A fire request only starts the pin pulse in reset mode when idle.
  assign rs_start = wr_rst && i_reset_mode && !rs_busy &&
    (i_bus.wdata[2:0] == hmrc_pkg::RESET_FIELD_FIRE);

  // Hour meter with write-back.
  always_comb begin
    next_loaded   = 1'b1;
    next_hours    = hours;
    next_fault    = fault;
    next_hours_wr = 1'b0;
    if (!loaded) begin
      next_hours = i_nv_hours;
      next_fault = i_nv_fault;
    end else if (wr_high || wr_low) begin
      if (wr_high) begin
        next_hours[HB-1:8] = i_bus.wdata[6:0];
        next_fault         = i_bus.wdata[hmrc_pkg::HOUR_FAULT_BIT];
      end
      if (wr_low) begin
        next_hours[7:0] = i_bus.wdata;
      end
      next_hours_wr = 1'b1;
    end else if (i_hour_tick) begin
      next_hours    = hours + HB'(1);
      next_hours_wr = 1'b1;
    end
  end

  // Data ready flags; a new result wins over a same-cycle read.
  always_comb begin
    next_ready = ready;
    for (int i = 0; i < RC; i++) begin
      if (i_conv_done[i]) begin
        next_ready[i] = 1'b1;
      end else if (i_result_read[i]) begin
        next_ready[i] = 1'b0;
      end
    end
  end

  // User control, power-on flag and host interrupt.
  always_comb begin
    next_ucfg     = ucfg;
    next_ucfg_wr  = 1'b0;
    next_por_flag = por_flag;
    next_ext_pend = ext_pend | i_irq_event;
    if (!loaded) begin
      next_ucfg = i_nv_user;
    end else if (wr_uc) begin
      next_ucfg.irq_mask   = i_bus.wdata[hmrc_pkg::UC_MASK_BIT];
      next_ucfg.irq_enable = i_bus.wdata[hmrc_pkg::UC_IE_BIT];
      next_ucfg.power_sel  = i_bus.wdata[hmrc_pkg::UC_PSEL_LSB +: 2];
      next_ucfg.mod_sel    = i_bus.wdata[hmrc_pkg::UC_MSEL_LSB +: 2];
      next_ucfg_wr         = 1'b1;
      if (i_bus.wdata[hmrc_pkg::UC_IE_BIT] && !int_n) begin
        next_ext_pend = i_irq_event;
      end
    end
    if (rd_uc) begin
      next_por_flag = 1'b0;
    end
    next_int_n = !(next_ucfg.irq_enable &&
      ((next_por_flag && next_ucfg.irq_mask) || next_ext_pend));
  end

  // Reset output field.
  always_comb begin
    next_rst_field = rst_field;
    if (rs_clear) begin
      next_rst_field = hmrc_pkg::RESET_FIELD_IDLE;
    end else if (wr_rst && !(rs_busy && i_reset_mode)) begin
      next_rst_field = i_bus.wdata[2:0];
    end
  end

  // Read data, one cycle after the read strobe.
  always_comb begin
    next_rdata  = 8'h00;
    next_rvalid = i_bus.rd;
    unique case (i_bus.addr)
      hmrc_pkg::ADDR_HOUR_HIGH:  next_rdata = {fault, hours[HB-1:8]};
      hmrc_pkg::ADDR_HOUR_LOW:   next_rdata = hours[7:0];
      hmrc_pkg::ADDR_DATA_READY: next_rdata = {ready, 3'b000};
      hmrc_pkg::ADDR_USER_CTRL:  next_rdata = {1'b0, ucfg.irq_mask,
        por_flag, ucfg.irq_enable, ucfg.power_sel, ucfg.mod_sel};
      hmrc_pkg::ADDR_RESET_OUT:  next_rdata = {5'b0_0000, rst_field};
      default:                   next_rdata = 8'h00;
    endcase
    if (!i_bus.rd) begin
      next_rdata = rdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      loaded    <= 1'b0;
      hours     <= '0;
      fault     <= 1'b0;
      hours_wr  <= 1'b0;
      ready     <= hmrc_pkg::DATA_READY_RESET[7:hmrc_pkg::READY_LSB];
      ucfg      <= '0;
      ucfg_wr   <= 1'b0;
      por_flag  <= hmrc_pkg::USER_CTRL_RESET[hmrc_pkg::UC_FLAG_BIT];
      ext_pend  <= 1'b0;
      int_n     <= 1'b1;
      rst_field <= hmrc_pkg::RESET_FIELD_IDLE;
      rdata     <= 8'h00;
      rvalid    <= 1'b0;
      o_pin_out <= 1'b0;
    end else begin
      loaded    <= next_loaded;
      hours     <= next_hours;
      fault     <= next_fault;
      hours_wr  <= next_hours_wr;
      ready     <= next_ready;
      ucfg      <= next_ucfg;
      ucfg_wr   <= next_ucfg_wr;
      por_flag  <= next_por_flag;
      ext_pend  <= next_ext_pend;
      int_n     <= next_int_n;
      rst_field <= next_rst_field;
      rdata     <= next_rdata;
      rvalid    <= next_rvalid;
      o_pin_out <= 1'b0;
    end
  end

  hmrc_reset_seq #(
    .PULSE_CYC (PULSE_CYC),
    .CLEAR_CYC (CLEAR_CYC)
  ) u_reset_seq (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_start   (rs_start),
    .o_drive   (rs_drive),
    .o_clear   (rs_clear),
    .o_busy    (rs_busy)
  );

  assign o_reg_rdata   = rdata;
  assign o_reg_rvalid  = rvalid;
  assign o_nv_hours    = hours;
  assign o_nv_hours_wr = hours_wr;
  assign o_nv_user     = ucfg;
  assign o_nv_user_wr  = ucfg_wr;
  assign o_int_n       = int_n;
  assign o_power_sel   = ucfg.power_sel;
  assign o_mod_sel     = ucfg.mod_sel;
  assign o_pin_oe      = rs_drive;

  a_irq_needs_ie: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !o_int_n |-> ucfg.irq_enable)
    else $error("interrupt asserted with global enable off");
  a_por_irq_on: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (ucfg.irq_enable && ucfg.irq_mask && por_flag) |-> !o_int_n)
    else $error("power-on interrupt not asserted");
  a_read_clears: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    rd_uc |=> !por_flag)
    else $error("power-on flag not cleared by read");
  a_ie_write_drop: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (loaded && wr_uc && i_bus.wdata[hmrc_pkg::UC_IE_BIT] && !o_int_n &&
     !i_irq_event && !(por_flag && i_bus.wdata[hmrc_pkg::UC_MASK_BIT]) &&
     !rd_uc) |=> o_int_n)
    else $error("interrupt not dropped by enable write");
  a_ready_set: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_conv_done[0] |=> ready[0])
    else $error("ready flag not set by new result");
  a_ready_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_result_read[RC-1] && !i_conv_done[RC-1]) |=> !ready[RC-1])
    else $error("ready flag not cleared by result read");
  a_hour_step: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (loaded && i_hour_tick && !wr_high && !wr_low) |=>
      (hours == $past(hours) + HB'(1)) && o_nv_hours_wr)
    else $error("hour count not stepped and written back");
  a_pin_mode: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (wr_rst && !i_reset_mode && !rs_busy) |=> !o_pin_oe)
    else $error("reset pin driven outside reset mode");
  a_field_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    rs_clear |=> (rst_field == hmrc_pkg::RESET_FIELD_IDLE))
    else $error("reset field not cleared after delay");
  a_sel_follow: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (loaded && wr_uc) |=> (o_power_sel == $past(i_bus.wdata[3:2])) &&
      (o_mod_sel == $past(i_bus.wdata[1:0])))
    else $error("setpoint selects do not follow write");

  c_por_irq: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !o_int_n && por_flag ##1 rd_uc ##1 o_int_n);
  c_pin_pulse: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    rs_start ##1 o_pin_oe);
  c_field_clear: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    rs_clear);
  c_hour_tick: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    loaded && i_hour_tick);
endmodule
`default_nettype wire

// >>> hmrc_regs_end.sv
// Empty unit that only restores the default net type.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> hmrc_host.sv
// Host model that issues single-byte register reads and writes.
`timescale 1ns/1ps
`default_nettype none
module hmrc_host (
  // Clock.
  input  wire logic                 i_ref_clk,
  // Register access.
  output var  hmrc_pkg::hmrc_bus_s  o_bus,
  input  wire logic [7:0]           i_rdata,
  input  wire logic                 i_rvalid
);
  initial o_bus = '0;

  // Released lines show the inverse of the last value, never a stale copy.
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge i_ref_clk);
    o_bus.addr = addr;
    o_bus.wdata = data;
    if (addr == hmrc_pkg::ADDR_USER_CTRL) begin
      o_bus.wdata[7] = 1'b0;
    end
    o_bus.wr = 1'b1;
    @(negedge i_ref_clk);
    o_bus.wr = 1'b0;
    o_bus.addr = ~o_bus.addr;
    o_bus.wdata = ~o_bus.wdata;
  endtask

  // Single-byte read; the answer is taken at the first edge with valid.
  task automatic rd(input logic [7:0] addr, output logic [7:0] data,
                    output logic ok);
    int k;
    ok = 1'b0;
    data = '0;
    @(negedge i_ref_clk);
    o_bus.addr = addr;
    o_bus.rd = 1'b1;
    for (k = 0; k < 4 && !ok; k++) begin
      @(negedge i_ref_clk);
      if (k == 0) begin
        o_bus.rd = 1'b0;
        o_bus.addr = ~o_bus.addr;
      end
      if (i_rvalid === 1'b1) begin
        data = i_rdata;
        ok = 1'b1;
      end
    end
  endtask

  // The hour pair is read as one block on adjacent cycles, but an hour tick
  // at the edge that samples the high byte still lands before the low byte.
  task automatic rd_pair(output logic [15:0] data, output logic ok);
    ok = 1'b0;
    data = '0;
    @(negedge i_ref_clk);
    o_bus.addr = hmrc_pkg::ADDR_HOUR_HIGH;
    o_bus.rd = 1'b1;
    @(negedge i_ref_clk);
    data[15:8] = i_rdata;
    ok = (i_rvalid === 1'b1);
    o_bus.addr = hmrc_pkg::ADDR_HOUR_LOW;
    @(negedge i_ref_clk);
    data[7:0] = i_rdata;
    ok = ok && (i_rvalid === 1'b1);
    o_bus.rd = 1'b0;
    o_bus.addr = ~o_bus.addr;
  endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking testbench for the register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                  i_ref_clk;
  logic                  i_rst_n;
  hmrc_pkg::hmrc_bus_s   bus;
  logic [7:0]            rdata;
  logic                  rvalid;
  logic [14:0]           nv_hours;
  logic [14:0]           hours_o;
  logic                  nv_fault;
  hmrc_pkg::hmrc_ucfg_s  nv_user;
  hmrc_pkg::hmrc_ucfg_s  user_o;
  logic                  hours_wr;
  logic                  user_wr;
  logic                  hour_tick;
  logic [4:0]            conv_done;
  logic [4:0]            result_read;
  logic                  irq_event;
  logic                  int_n;
  logic [1:0]            power_sel;
  logic [1:0]            mod_sel;
  logic                  reset_mode;
  logic                  pin_out;
  logic                  pin_oe;
  int                    n_mismatch;
  int                    samples_checked;

  hmrc_host host (.i_ref_clk(i_ref_clk), .o_bus(bus), .i_rdata(rdata),
                  .i_rvalid(rvalid));

  hmrc_regs #(.PULSE_CYC(8), .CLEAR_CYC(20)) dut (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_bus(bus),
    .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_nv_hours(nv_hours),
    .i_nv_fault(nv_fault), .i_nv_user(nv_user), .o_nv_hours(hours_o),
    .o_nv_hours_wr(hours_wr), .o_nv_user(user_o), .o_nv_user_wr(user_wr),
    .i_hour_tick(hour_tick), .i_conv_done(conv_done),
    .i_result_read(result_read), .i_irq_event(irq_event), .o_int_n(int_n),
    .o_power_sel(power_sel), .o_mod_sel(mod_sel),
    .i_reset_mode(reset_mode), .o_pin_out(pin_out), .o_pin_oe(pin_oe));

  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  // Non-volatile image keeps whatever the bank writes back.
  always @(posedge i_ref_clk) begin
    if (hours_wr === 1'b1) nv_hours <= hours_o;
    if (user_wr === 1'b1) nv_user <= user_o;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string w, input logic [15:0] s,
                     input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", w, e, s);
      n_mismatch++;
    end
  endtask

  task automatic rdc(input string w, input logic [7:0] a,
                     input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    host.rd(a, d, ok);
    chk({w, "_answer"}, 16'(ok), 16'h0001);
    if (ok !== 1'b1) summarize();
    chk(w, 16'(d), 16'(e));
  endtask

  task automatic do_reset();
    i_rst_n = 1'b0;
    repeat (6) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    repeat (2) @(negedge i_ref_clk);
  endtask

  // Pulses one event input for one cycle.
  task automatic ev(input int sel, input logic [4:0] v);
    @(negedge i_ref_clk);
    case (sel)
      0: conv_done = v;
      1: result_read = v;
      2: irq_event = v[0];
      default: hour_tick = v[0];
    endcase
    @(negedge i_ref_clk);
    conv_done = '0;
    result_read = '0;
    irq_event = 1'b0;
    hour_tick = 1'b0;
  endtask

  task automatic t_power_on();
    logic [15:0] pair;
    logic        ok;
    nv_user = '{1'b1, 1'b1, 2'b10, 2'b01};
    nv_hours = 15'h5A3C;
    nv_fault = 1'b1;
    do_reset();
    chk("int_n_por", 16'(int_n), 16'h0000);
    chk("power_sel", 16'(power_sel), 16'h0002);
    chk("mod_sel", 16'(mod_sel), 16'h0001);
    rdc("uc_first", hmrc_pkg::ADDR_USER_CTRL, 8'h79);
    chk("int_n_read", 16'(int_n), 16'h0001);
    rdc("uc_second", hmrc_pkg::ADDR_USER_CTRL, 8'h59);
    rdc("hour_high", hmrc_pkg::ADDR_HOUR_HIGH, 8'hDA);
    rdc("hour_low", hmrc_pkg::ADDR_HOUR_LOW, 8'h3C);
    host.rd_pair(pair, ok);
    chk("hour_pair_answer", 16'(ok), 16'h0001);
    chk("hour_pair", pair, 16'hDA3C);
    rdc("ready_rst", hmrc_pkg::ADDR_DATA_READY, 8'h00);
    rdc("rstout_rst", hmrc_pkg::ADDR_RESET_OUT, 8'h00);
    rdc("unmapped", 8'h10, 8'h00);
    ev(3, 5'h01);
    chk("hours_wr", 16'(hours_wr), 16'h0001);
    chk("hours_nv", 16'(hours_o), 16'h5A3D);
    rdc("hour_tick", hmrc_pkg::ADDR_HOUR_LOW, 8'h3D);
    $display("t_power_on done");
  endtask

  task automatic t_ready();
    for (int i = 0; i < 5; i++) begin
      ev(0, 5'(1 << i));
      rdc("ready_set", hmrc_pkg::ADDR_DATA_READY, 8'(1 << (i + 3)));
      ev(1, 5'(1 << i));
      rdc("ready_clr", hmrc_pkg::ADDR_DATA_READY, 8'h00);
    end
    @(negedge i_ref_clk);
    conv_done = 5'b10000;
    result_read = 5'b10000;
    ev(0, 5'b10000);
    rdc("ready_race", hmrc_pkg::ADDR_DATA_READY, 8'h80);
    $display("t_ready done");
  endtask

  task automatic t_selects();
    for (int v = 0; v < 4; v++) begin
      host.wr(hmrc_pkg::ADDR_USER_CTRL, {4'h0, 2'(v), 2'(3 - v)});
      chk("psel", 16'(power_sel), 16'(v));
      chk("msel", 16'(mod_sel), 16'(3 - v));
      rdc("uc_sel", hmrc_pkg::ADDR_USER_CTRL, 8'(v * 4 + 3 - v));
    end
    do_reset();
    chk("psel_kept", 16'(power_sel), 16'h0003);
    rdc("hours_kept", hmrc_pkg::ADDR_HOUR_LOW, 8'h3D);
    $display("t_selects done");
  endtask

  task automatic t_irq();
    ev(2, 5'h01);
    chk("int_ie_off", 16'(int_n), 16'h0001);
    host.wr(hmrc_pkg::ADDR_USER_CTRL, 8'h43);
    chk("int_mask_only", 16'(int_n), 16'h0001);
    host.wr(hmrc_pkg::ADDR_USER_CTRL, 8'h53);
    chk("int_mask_set", 16'(int_n), 16'h0000);
    host.wr(hmrc_pkg::ADDR_USER_CTRL, 8'h53);
    chk("int_held", 16'(int_n), 16'h0000);
    rdc("uc_flag", hmrc_pkg::ADDR_USER_CTRL, 8'h73);
    chk("int_read", 16'(int_n), 16'h0001);
    ev(2, 5'h01);
    chk("int_ext", 16'(int_n), 16'h0000);
    host.wr(hmrc_pkg::ADDR_USER_CTRL, 8'h13);
    chk("int_ie_write", 16'(int_n), 16'h0001);
    $display("t_irq done");
  endtask

  task automatic t_pin();
    int n;
    n = 0;
    host.wr(hmrc_pkg::ADDR_RESET_OUT, 8'hFF);
    repeat (12) begin
      n += int'(pin_oe === 1'b1);
      @(negedge i_ref_clk);
    end
    chk("pin_no_mode", 16'(n), 16'h0000);
    rdc("rstout_ro", hmrc_pkg::ADDR_RESET_OUT, 8'h07);
    host.wr(hmrc_pkg::ADDR_RESET_OUT, 8'h00);
    reset_mode = 1'b1;
    host.wr(hmrc_pkg::ADDR_RESET_OUT, 8'h03);
    chk("pin_not_fire", 16'(pin_oe), 16'h0000);
    host.wr(hmrc_pkg::ADDR_RESET_OUT, 8'h07);
    n = 0;
    for (int k = 0; k < 40; k++) begin
      if (pin_oe === 1'b1) n++;
      else if (n > 0) break;
      @(negedge i_ref_clk);
    end
    chk("pin_width", 16'(n), 16'h0008);
    chk("pin_level", 16'(pin_out), 16'h0000);
    rdc("field_held", hmrc_pkg::ADDR_RESET_OUT, 8'h07);
    // The field still reads 111 when sampled at the same edge that clears it.
    repeat (17) @(negedge i_ref_clk);
    rdc("field_late", hmrc_pkg::ADDR_RESET_OUT, 8'h07);
    rdc("field_clear", hmrc_pkg::ADDR_RESET_OUT, 8'h00);
    $display("t_pin done");
  endtask

  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    i_rst_n = 1'b0;
    nv_hours = '0;
    nv_fault = 1'b0;
    nv_user = '0;
    hour_tick = 1'b0;
    conv_done = '0;
    result_read = '0;
    irq_event = 1'b0;
    reset_mode = 1'b0;
    t_power_on();
    t_ready();
    t_selects();
    t_irq();
    t_pin();
    summarize();
  end
endmodule
`default_nettype wire
